// ===== common/lid_pkg.sv
//
// Contract
// R1: Page one code 0001 sets line scroll enables
// R2: Function set carries bus width, rows, page
// R3: Primary page zero: pan_not_scroll and inversion bits
// R4: Page one function set: glyph flash bit
// R5: Page zero code 01 loads glyph address
// R6: Page one code 01 loads icon address
// R7: Page zero bit7 loads character address
// R8: Page one bit7 loads dot scroll amount
// R9: Status read returns busy bit, no delay
// R10: Second consecutive status read returns part code
// R11: Serial mode reads only via continuous read
// R12: Data write stores into selected RAM
// R13: Data read returns selected RAM byte
// R14: Host waits half oscillator period after ready
// R15: Busy times: clear/home, control, data
// R16: Alternate set auto pan shifts all lines
// R17: Clear fills character RAM, address zero
// R18: Home zeroes address, undoes display shift
// R19: Page zero 00001: screen, pointer, flash
// R20: Page one 00001: font, invert, four rows
// R21: Page zero 0001: shift select and bias
// R22: Alternate set ignores function set bits 1:0; code sets glyph flash from bit 1 on page one
// R23: Table select high primary, low alternate
// R24: Stored page bit decodes page commands
package lid_pkg;

    // -------------------------------------------------------------------
    // Timing
    // -------------------------------------------------------------------
    localparam int unsigned CLK_NS = 10;
    localparam int unsigned T_CLEAR_NS = 1530000;
    localparam int unsigned T_CTRL_NS = 39000;
    localparam int unsigned T_DATA_NS = 43000;
    localparam int unsigned CLEAR_CYC = (T_CLEAR_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned CTRL_CYC = (T_CTRL_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DATA_CYC = (T_DATA_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BUSY_W = 18;

    // -------------------------------------------------------------------
    // Register map (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_DATA = 8'h04;
    localparam logic [7:0] OFS_CFG = 8'h08;
    localparam logic [7:0] OFS_CTRL = 8'h0c;
    localparam logic [7:0] OFS_FLAGS = 8'h10;

    // Field positions
    localparam int unsigned CTRL_SERIAL_BIT = 0;
    localparam int unsigned CTRL_CONT_BIT = 1;
    localparam int unsigned FLAG_OVERRUN_BIT = 0;
    localparam int unsigned FLAG_TABLE_BIT = 1;

    // Reset and fill values
    localparam logic [7:0] SPACE_CODE = 8'h20;
    localparam logic [6:0] AC_HOME = 7'h00;
    localparam logic [1:0] BIAS_RST = 2'h2;
    localparam logic [6:0] PART_CODE_DEF = 7'h2a; // Arbitrary value
    localparam int unsigned CHAR_DEPTH = 128;
    localparam int unsigned GLYPH_DEPTH = 64;
    localparam int unsigned ICON_DEPTH = 16;

    typedef enum logic [1:0] {RAM_CHAR, RAM_GLYPH, RAM_ICON} lid_ram_t;

    // Display configuration visible to the panel logic
    typedef struct packed {
        logic bus_width_8;
        logic two_row;
        logic pan_not_scroll;
        logic invert_screen;
        logic glyph_ram_flash;
        logic [3:0] line_dot_scroll_en;
        logic [5:0] dot_scroll_amount;
        logic screen_on;
        logic pointer_shown;
        logic pointer_flash;
        logic wide_font;
        logic cursor_invert;
        logic four_row;
        logic pan_or_pointer;
        logic move_right;
        logic [1:0] bias_select;
        logic inc_dir;
        logic auto_pan;
        logic [6:0] shift_pos;
    } lid_cfg_t;

    localparam int unsigned CFG_W = $bits(lid_cfg_t);

endpackage

// ===== design/lid_top.sv
`timescale 1ns/1ps
module lid_top import lid_pkg::*; #(
    parameter int unsigned CLEAR_CYCLES = CLEAR_CYC,
    parameter int unsigned DATA_CYCLES = DATA_CYC,
    parameter logic [6:0] PART_CODE = PART_CODE_DEF // Arbitrary value
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic instruction_table_select,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic busy_flag,
    output lid_cfg_t disp_cfg
);

    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    typedef struct packed {
        lid_cfg_t cfg;
        logic [6:0] address_counter;
        lid_ram_t ram_sel;
        logic extended_page;
        logic status_second;
        logic [BUSY_W-1:0] busy_cnt;
        logic busy;
        logic serial_mode;
        logic cont_read;
        logic overrun;
        logic tsel_meta;
        logic tsel_sync;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } lid_state_t;

    lid_state_t st_reg;
    lid_state_t st_next;

    logic [7:0] char_ram [CHAR_DEPTH];
    logic [7:0] glyph_ram [GLYPH_DEPTH];
    logic [7:0] icon_ram [ICON_DEPTH];

    logic access;
    logic setup;
    logic cmd_take;
    logic data_wr;
    logic data_rd_take;
    logic stat_rd;
    logic rd_blocked;
    logic clear_fill;
    logic [7:0] cmd;
    logic [7:0] ram_q;

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    // Step the address counter and wrap it to the size of the target RAM
    function automatic logic [6:0] ac_step(input logic [6:0] ac, input lid_ram_t sel,
                                          input logic up);
        logic [6:0] n;
        n = up ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
        case (sel)
            RAM_GLYPH: ac_step = {1'b0, n[5:0]};
            RAM_ICON: ac_step = {3'b000, n[3:0]};
            default: ac_step = n;
        endcase
    endfunction

    function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] ofs);
        is_ofs = (a == ofs);
    endfunction

    // Access phase is where a transfer takes effect; pready is always high there
    assign setup = psel & ~penable;
    assign access = psel & penable & st_reg.pready;
    assign cmd = pwdata[7:0];
    // Serial link has no plain read path, only continuous read
    assign rd_blocked = st_reg.serial_mode & ~st_reg.cont_read; // [R11]
    assign cmd_take = access & pwrite & is_ofs(paddr, OFS_CMD) & ~st_reg.busy;
    assign data_wr = access & pwrite & is_ofs(paddr, OFS_DATA) & ~st_reg.busy;
    assign data_rd_take = access & ~pwrite & is_ofs(paddr, OFS_DATA) & ~st_reg.busy
                          & ~rd_blocked;
    assign stat_rd = access & ~pwrite & is_ofs(paddr, OFS_CMD) & ~rd_blocked;
    assign clear_fill = cmd_take & (cmd == 8'h01);

    // Byte at the address counter in whichever RAM was last addressed
    always_comb begin
        case (st_reg.ram_sel)
            RAM_GLYPH: ram_q = glyph_ram[st_reg.address_counter[5:0]]; // [R13]
            RAM_ICON: ram_q = icon_ram[st_reg.address_counter[3:0]];
            default: ram_q = char_ram[st_reg.address_counter];
        endcase
    end

    // -------------------------------------------------------------------
    // Next state
    // -------------------------------------------------------------------
    always_comb begin
        logic prim;
        logic ep;
        logic [BUSY_W-1:0] load;
        prim = st_reg.tsel_sync;
        ep = st_reg.extended_page;
        load = '0;
        st_next = st_reg;

        // Strap crosses two flops; the first is read only by the second
        st_next.tsel_meta = instruction_table_select;
        st_next.tsel_sync = st_reg.tsel_meta;

        // Busy countdown; status reads stay legal while it runs
        if (st_reg.busy_cnt != '0) begin
            st_next.busy_cnt = st_reg.busy_cnt - 1'b1;
        end

        // Instruction decode, page bit taken from stored state
        if (cmd_take) begin
            load = BUSY_W'(CTRL_CYC); // [R15]
            if (cmd == 8'h01) begin
                st_next.address_counter = AC_HOME; // [R17]
                st_next.ram_sel = RAM_CHAR;
                st_next.cfg.inc_dir = 1'b1;
                st_next.cfg.shift_pos = '0;
                load = BUSY_W'(CLEAR_CYCLES); // [R15]
            end else if (cmd[7:1] == 7'h01) begin
                // Primary page one decodes this as power down, which lives elsewhere
                if (!(prim && ep)) begin
                    st_next.address_counter = AC_HOME; // [R18]
                    st_next.ram_sel = RAM_CHAR;
                    st_next.cfg.shift_pos = '0; // [R18]
                    load = BUSY_W'(CLEAR_CYCLES); // [R15]
                end
            end else if (cmd[7:2] == 6'h01) begin
                if (!(prim && ep)) begin
                    st_next.cfg.inc_dir = cmd[1];
                    st_next.cfg.auto_pan = cmd[0];
                end
            end else if (cmd[7:3] == 5'h01) begin
                if (ep) begin
                    st_next.cfg.wide_font = cmd[2]; // [R20]
                    st_next.cfg.cursor_invert = cmd[1];
                    st_next.cfg.four_row = cmd[0];
                end else begin
                    st_next.cfg.screen_on = cmd[2]; // [R19]
                    st_next.cfg.pointer_shown = cmd[1];
                    st_next.cfg.pointer_flash = cmd[0];
                end
            end else if (cmd[7:4] == 4'h1) begin
                if (ep) begin
                    // Same four bits act as line shift enables when panning
                    st_next.cfg.line_dot_scroll_en = cmd[3:0]; // [R1]
                end else begin
                    st_next.cfg.pan_or_pointer = cmd[3]; // [R21]
                    st_next.cfg.move_right = cmd[2];
                    st_next.cfg.bias_select = cmd[1:0];
                    if (cmd[3]) begin
                        st_next.cfg.shift_pos = cmd[2] ? 7'(st_reg.cfg.shift_pos + 7'h01)
                                                       : 7'(st_reg.cfg.shift_pos - 7'h01);
                    end else begin
                        st_next.address_counter = ac_step(st_reg.address_counter,
                                                          st_reg.ram_sel, cmd[2]);
                    end
                end
            end else if (cmd[7:5] == 3'h1) begin
                st_next.cfg.bus_width_8 = cmd[4]; // [R2]
                st_next.cfg.two_row = cmd[3];
                st_next.extended_page = cmd[2]; // [R24]
                if (cmd[2]) begin
                    st_next.cfg.glyph_ram_flash = cmd[1]; // [R4]
                end else if (prim) begin
                    st_next.cfg.pan_not_scroll = cmd[1]; // [R3]
                    st_next.cfg.invert_screen = cmd[0];
                end
                // Alternate set leaves bits 1:0 unused on page zero [R22]
            end else if (cmd[7:6] == 2'h1) begin
                if (ep) begin
                    st_next.address_counter = {3'b000, cmd[3:0]}; // [R6]
                    st_next.ram_sel = RAM_ICON;
                end else begin
                    st_next.address_counter = {1'b0, cmd[5:0]}; // [R5]
                    st_next.ram_sel = RAM_GLYPH;
                end
            end else if (cmd[7]) begin
                if (ep) begin
                    st_next.cfg.dot_scroll_amount = cmd[5:0]; // [R8]
                end else begin
                    st_next.address_counter = cmd[6:0]; // [R7]
                    st_next.ram_sel = RAM_CHAR;
                end
            end
        end

        // Data transfers move the counter in the entry direction
        if (data_wr || data_rd_take) begin
            load = BUSY_W'(DATA_CYCLES); // [R15]
            st_next.address_counter = ac_step(st_reg.address_counter, st_reg.ram_sel,
                                              st_reg.cfg.inc_dir);
            // Pan tracks char writes; alternate set pans every line [R16]
            if (data_wr && st_reg.cfg.auto_pan && st_reg.ram_sel == RAM_CHAR) begin
                st_next.cfg.shift_pos = st_reg.cfg.inc_dir ? 7'(st_reg.cfg.shift_pos - 7'h01)
                                                           : 7'(st_reg.cfg.shift_pos + 7'h01);
            end
        end

        if (load != '0) begin
            st_next.busy_cnt = load;
        end
        st_next.busy = (st_next.busy_cnt != '0);

        // Status alternates counter and part code on back-to-back reads [R10]
        if (stat_rd) begin
            st_next.status_second = ~st_reg.status_second;
        end else if (access && (is_ofs(paddr, OFS_CMD) || is_ofs(paddr, OFS_DATA))) begin
            st_next.status_second = 1'b0;
        end

        // Control and sticky flag; a new overrun wins over a clear
        if (access && pwrite && is_ofs(paddr, OFS_CTRL)) begin
            st_next.serial_mode = pwdata[CTRL_SERIAL_BIT];
            st_next.cont_read = pwdata[CTRL_CONT_BIT];
        end
        if (access && pwrite && is_ofs(paddr, OFS_FLAGS) && pwdata[FLAG_OVERRUN_BIT]) begin
            st_next.overrun = 1'b0;
        end
        if (access && st_reg.busy && (is_ofs(paddr, OFS_CMD) || is_ofs(paddr, OFS_DATA))
            && (pwrite || is_ofs(paddr, OFS_DATA))) begin
            st_next.overrun = 1'b1;
        end

        // Bus answer: one access cycle, data prepared in setup
        st_next.pready = setup;
        st_next.pslverr = 1'b0;
        if (!setup) begin
            st_next.prdata = '0;
        end else begin
            st_next.prdata = '0;
            case (paddr)
                OFS_CMD: begin
                    st_next.pslverr = ~pwrite & rd_blocked;
                    if (!pwrite && !rd_blocked) begin
                        st_next.prdata[7] = st_reg.busy; // [R9]
                        st_next.prdata[6:0] = st_reg.status_second ? PART_CODE
                                                                   : st_reg.address_counter;
                    end
                end
                OFS_DATA: begin
                    st_next.pslverr = ~pwrite & rd_blocked;
                    if (!pwrite && !rd_blocked) begin
                        st_next.prdata[7:0] = ram_q; // [R13]
                    end
                end
                // Pan position is live state, not a setting; leaving it out lets
                // the rest of the configuration fit one bus word
                OFS_CFG: st_next.prdata[CFG_W-8:0] = st_reg.cfg[CFG_W-1:7];
                OFS_CTRL: begin
                    st_next.prdata[CTRL_SERIAL_BIT] = st_reg.serial_mode;
                    st_next.prdata[CTRL_CONT_BIT] = st_reg.cont_read;
                end
                OFS_FLAGS: begin
                    st_next.prdata[FLAG_OVERRUN_BIT] = st_reg.overrun;
                    st_next.prdata[FLAG_TABLE_BIT] = st_reg.tsel_sync; // [R23]
                end
                default: st_next.pslverr = 1'b1;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.cfg.bias_select <= BIAS_RST;
            st_reg.cfg.inc_dir <= 1'b1;
            st_reg.cfg.bus_width_8 <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // RAM writes; clear fills the whole char RAM in one edge
    always_ff @(posedge pclk) begin
        if (clear_fill) begin
            for (int i = 0; i < CHAR_DEPTH; i++) begin
                char_ram[i] <= SPACE_CODE; // [R17]
            end
        end else if (data_wr) begin
            case (st_reg.ram_sel)
                RAM_GLYPH: glyph_ram[st_reg.address_counter[5:0]] <= cmd; // [R12]
                RAM_ICON: icon_ram[st_reg.address_counter[3:0]] <= cmd;
                default: char_ram[st_reg.address_counter] <= cmd; // [R12]
            endcase
        end
    end

    assign pready = st_reg.pready;
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;
    assign busy_flag = st_reg.busy;
    assign disp_cfg = st_reg.cfg;

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_cmd(logic [7:0] mask, logic [7:0] val);
        cmd_take && ((cmd & mask) == val);
    endsequence

    // Two status reads with no other access between, the first showing the counter
    sequence s_stat_pair;
        (stat_rd && !st_reg.status_second) ##1 !access [*3] ##1 stat_rd;
    endsequence

    a_busy_ctrl_len: assert property (s_cmd(8'h80, 8'h80) |=> // [R15]
        busy_flag && st_reg.busy_cnt == BUSY_W'(CTRL_CYC))
        else $error("Control busy time wrong");
    a_clear_home: assert property (s_cmd(8'hff, 8'h01) |=> // [R17]
        st_reg.address_counter == AC_HOME && st_reg.ram_sel == RAM_CHAR
        && st_reg.busy_cnt == BUSY_W'(CLEAR_CYCLES))
        else $error("Clear did not home counter");
    a_home_unshift: assert property ((s_cmd(8'hfe, 8'h02) ##0 !(st_reg.tsel_sync // [R18]
        && st_reg.extended_page)) |=> st_reg.address_counter == AC_HOME
        && disp_cfg.shift_pos == '0)
        else $error("Home left a shift");
    a_status_busy: assert property ((access && !pwrite && is_ofs(paddr, OFS_CMD) // [R9]
        && !rd_blocked) |-> prdata[7] == $past(st_reg.busy))
        else $error("Status busy bit wrong");
    a_second_part: assert property (s_stat_pair |-> prdata[6:0] == PART_CODE) // [R10]
        else $error("Second status read lacks part code");
    a_page_store: assert property (s_cmd(8'he0, 8'h20) |=> // [R24]
        st_reg.extended_page == $past(cmd[2]))
        else $error("Page bit not stored");
    a_scroll_qty: assert property ((s_cmd(8'h80, 8'h80) ##0 st_reg.extended_page) |=> // [R8]
        disp_cfg.dot_scroll_amount == $past(cmd[5:0]))
        else $error("Scroll amount not loaded");
    a_char_addr: assert property ((s_cmd(8'h80, 8'h80) ##0 !st_reg.extended_page) |=> // [R7]
        st_reg.address_counter == $past(cmd[6:0]) && st_reg.ram_sel == RAM_CHAR)
        else $error("Char address not loaded");
    a_serial_block: assert property ((setup && !pwrite && rd_blocked // [R11]
        && (is_ofs(paddr, OFS_CMD) || is_ofs(paddr, OFS_DATA))) |=> pslverr && prdata == '0)
        else $error("Serial plain read not refused");
    a_alt_ignore: assert property ((s_cmd(8'he4, 8'h20) ##0 !st_reg.tsel_sync) |=> // [R22]
        $stable(disp_cfg.invert_screen) && $stable(disp_cfg.pan_not_scroll))
        else $error("Alternate set changed inversion");

endmodule

// ===== verif/lid_host.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host processor model on the register bus
// ----------------------------------------------------------------
module lid_host (
    input wire logic pclk,
    input wire logic presetn,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic busy_flag
);
    // Half an oscillator period at 270 kHz, rounded up to whole cycles
    localparam int HALF_OSC = 186;

    // Idle bus at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // One transfer; the request stands until pready is seen high
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        wait (presetn === 1'b1);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait-state count is assumed; only the bench timeout ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // Stale data must never look valid
    endtask

    // Count busy cycles, then add the settling gap before the next command
    task automatic finish(output int n);
        n = 0;
        @(posedge pclk);
        while (busy_flag === 1'b1 && n < 200000) begin
            n++;
            @(posedge pclk);
        end
        repeat (HALF_OSC) @(posedge pclk);
    endtask
endmodule

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top import lid_pkg::*; ;
    // Short busy counts keep the run brief
    localparam int CLR_N = 50;
    localparam int DAT_N = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic table_sel = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, busy_flag, pg, prim;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    lid_cfg_t cfg, ec;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;

    always #5 pclk = ~pclk;

    lid_top #(.CLEAR_CYCLES(CLR_N), .DATA_CYCLES(DAT_N)) lid_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .instruction_table_select(table_sel),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .busy_flag(busy_flag),
        .disp_cfg(cfg)
    );
    lid_host lid_host_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .busy_flag(busy_flag)
    );

    // ----------------------------------------------------------------
    // Checking and expectation helpers
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic give_verdict;
        if (fails == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Expected configuration after one instruction
    function automatic void model(input logic [7:0] i);
        if (i == 8'h01) begin
            ec.inc_dir = 1'b1;
        end else if (i[7:2] == 6'h01 && !(pg && prim)) begin
            {ec.inc_dir, ec.auto_pan} = i[1:0];
        end else if (i[7:3] == 5'h01) begin
            if (pg) begin
                {ec.wide_font, ec.cursor_invert, ec.four_row} = i[2:0];
            end else begin
                {ec.screen_on, ec.pointer_shown, ec.pointer_flash} = i[2:0];
            end
        end else if (i[7:4] == 4'h1) begin
            if (pg) begin
                ec.line_dot_scroll_en = i[3:0];
            end else begin
                {ec.pan_or_pointer, ec.move_right, ec.bias_select} = i[3:0];
            end
        end else if (i[7:5] == 3'h1) begin
            {ec.bus_width_8, ec.two_row, pg} = i[4:2];
            if (pg) begin
                ec.glyph_ram_flash = i[1];
            end else if (prim) begin
                {ec.pan_not_scroll, ec.invert_screen} = i[1:0];
            end
        end else if (i[7] && pg) begin
            ec.dot_scroll_amount = i[5:0];
        end
    endfunction

    // Shift position moves by itself, so it is compared apart
    task automatic cfg_chk;
        lid_cfg_t s;
        lid_cfg_t e;
        s = cfg;
        e = ec;
        s.shift_pos = '0;
        e.shift_pos = '0;
        check("cfg", 64'(s), 64'(e));
    endtask

    task automatic wr(input logic [7:0] c, input int nb = CTRL_CYC, input logic [7:0] a = OFS_CMD);
        logic [31:0] r;
        logic e;
        int n;
        lid_host_i.xfer(1'b1, a, {24'h0, c}, r, e);
        lid_host_i.finish(n);
        if (a == OFS_CMD) model(c);
        check("busy_cycles", 64'(n), 64'(nb));
    endtask

    task automatic rdx(input logic [7:0] a, input logic [31:0] ex, input logic ee, input string nm);
        logic [31:0] r;
        logic e;
        lid_host_i.xfer(1'b0, a, 32'h0, r, e);
        check({nm, "_err"}, 64'(e), 64'(ee));
        if (ee === 1'b0) check(nm, 64'(r), 64'(ex));
    endtask

    task automatic drd(input logic [7:0] ex);
        int n;
        rdx(OFS_DATA, {24'h0, ex}, 1'b0, "ram_data");
        lid_host_i.finish(n);
    endtask

    // Give up if the sequence hangs
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 95000) begin
            fails++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic e;
        logic [7:0] a, b, d[4];
        int n;
        void'($urandom(22));
        ec = '0;
        ec.bias_select = BIAS_RST;
        {ec.inc_dir, ec.bus_width_8, pg, prim} = 4'b1101;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // The strap crosses two flops before the flags word shows it
        repeat (2) @(posedge pclk);
        cfg_chk();
        rdx(OFS_FLAGS, 32'h2, 1'b0, "flags");
        rdx(8'h14, 32'h0, 1'b1, "unmapped");
        wr(8'h20 | (8'($urandom) & 8'h1b));
        cfg_chk();
        rdx(OFS_CFG, 32'(ec >> 7), 1'b0, "cfg_word");
        wr(8'h08 | (8'($urandom) & 8'h07));
        cfg_chk();
        wr(8'h18 | (8'($urandom) & 8'h07));
        cfg_chk();
        a = (8'($urandom) & 8'h3f) | 8'h01; // Not cell zero, rewritten after clear
        wr(8'h80 | a);
        rdx(OFS_CMD, 32'(a), 1'b0, "status");
        @(posedge pclk);
        check("status_no_busy", 64'(busy_flag), 64'h0);
        rdx(OFS_CMD, 32'(PART_CODE_DEF), 1'b0, "part");
        lid_host_i.xfer(1'b1, OFS_CTRL, 32'h1, r, e);
        rdx(OFS_CMD, 32'h0, 1'b1, "plain_serial");
        lid_host_i.xfer(1'b1, OFS_CTRL, 32'h3, r, e);
        rdx(OFS_CMD, 32'(a), 1'b0, "cont_status");
        lid_host_i.xfer(1'b1, OFS_CTRL, 32'h0, r, e);
        for (int k = 0; k < 4; k++) begin
            d[k] = 8'($urandom);
            wr(d[k], DAT_N, OFS_DATA);
        end
        rdx(OFS_CMD, 32'(a + 8'd4), 1'b0, "ac_step");
        wr(8'h80 | a);
        for (int k = 0; k < 4; k++) drd(d[k]);
        // Commands during busy are dropped and flagged
        b = 8'($urandom) & 8'h7f;
        lid_host_i.xfer(1'b1, OFS_CMD, 32'h80 | 32'(b), r, e);
        rdx(OFS_CMD, 32'h80 | 32'(b), 1'b0, "busy_status");
        lid_host_i.xfer(1'b1, OFS_CMD, 32'h01, r, e);
        lid_host_i.finish(n);
        rdx(OFS_FLAGS, 32'h3, 1'b0, "overrun");
        lid_host_i.xfer(1'b1, OFS_FLAGS, 32'h1, r, e);
        rdx(OFS_FLAGS, 32'h2, 1'b0, "overrun_clr");
        b = 8'($urandom) & 8'h3f;
        wr(8'h40 | b);
        wr(d[0], DAT_N, OFS_DATA);
        wr(8'h40 | b);
        drd(d[0]);
        wr(8'h24 | (8'($urandom) & 8'h1a));
        cfg_chk();
        b = 8'($urandom % 15);
        wr(8'h70 | b);
        wr(d[1], DAT_N, OFS_DATA);
        wr(8'h70 | b);
        drd(d[1]);
        wr(8'h10 | (8'($urandom) & 8'h0f));
        cfg_chk();
        wr(8'hc0 | (8'($urandom) & 8'h3f));
        cfg_chk();
        rdx(OFS_CMD, 32'(b + 8'd1), 1'b0, "ac_kept");
        wr(8'h08 | (8'($urandom) & 8'h07));
        cfg_chk();
        wr(8'h01, CLR_N);
        rdx(OFS_CMD, 32'h0, 1'b0, "clear_ac");
        cfg_chk();
        wr(8'h20);
        wr(d[2], DAT_N, OFS_DATA);
        wr(8'h80 | a);
        drd(8'h20);
        wr(8'h1c);
        wr(8'h02, CLR_N);
        check("home_shift", 64'(cfg.shift_pos), 64'h0);
        drd(d[2]);
        table_sel <= 1'b0;
        repeat (3) @(posedge pclk);
        prim = 1'b0;
        rdx(OFS_FLAGS, 32'h0, 1'b0, "strap_low");
        wr(8'h23);
        cfg_chk();
        wr(8'h07);
        wr(d[3], DAT_N, OFS_DATA);
        check("auto_pan", 64'(cfg.shift_pos != 7'h0), 64'h1);
        give_verdict();
    end
endmodule
